// [chcar_bank_swap.sv]
`timescale 1ns/1ps
module chcar_bank_swap
	import chcar_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// control
	input  wire logic frame_boundary,
	input  wire logic adaptive_en,
	input  wire logic swap_req,
	// status
	output logic      swap_now,
	output logic      bank_flag
);

	typedef struct packed
	{
		logic flag;
	} chcar_swap_s;

	chcar_swap_s state;
	chcar_swap_s next_state;

	// swap only at a frame boundary in adaptive mode
	assign swap_now = frame_boundary & adaptive_en & swap_req; // R13 R16

	always_comb
	begin
		next_state = state;
		if (swap_now)
			next_state.flag = ~state.flag; // R16
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state <= '0;
		else
			state <= next_state;
	end

	assign bank_flag = state.flag; // R12

endmodule

// [chcar_cp_divider.sv]
`timescale 1ns/1ps
module chcar_cp_divider
	import chcar_pkg::*;
#(
	parameter int RATIO_W = 7
)
(
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset,
	// division ratio
	input  wire logic [RATIO_W-1:0] ratio,
	// enable pulse out
	output logic                    tick
);

	typedef struct packed
	{
		logic [RATIO_W-1:0] count;
		logic               tick;
	} chcar_div_s;

	chcar_div_s state;
	chcar_div_s next_state;

	always_comb
	begin
		next_state      = state;
		next_state.tick = 1'b0;
		if (state.count >= ratio - RATIO_W'(1))
		begin
			next_state.count = '0;
			next_state.tick  = 1'b1;
		end
		else
		begin
			next_state.count = state.count + RATIO_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			state <= '0;
		else
			state <= next_state;
	end

	assign tick = state.tick;

endmodule

// [chcar_host_model.sv]
`timescale 1ns/1ps
module chcar_host_model
(
	// clock
	input  wire logic       clk_sys,
	// register port
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial
	begin
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// one-cycle write, bus inverted once released
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
endmodule

// [chcar_pkg.sv]
package chcar_pkg;

	typedef enum logic [1:0]
	{
		chcar_couple_independent,
		chcar_couple_right_master,
		chcar_couple_left_master,
		chcar_couple_reserved
	} chcar_couple_e;

	typedef enum logic [1:0]
	{
		chcar_power_100,
		chcar_power_75,
		chcar_power_50,
		chcar_power_25
	} chcar_power_e;

	typedef enum logic [1:0]
	{
		chcar_dcoc_off,
		chcar_dcoc_reserved,
		chcar_dcoc_enabled_routes,
		chcar_dcoc_all_routes
	} chcar_dcoc_e;

	typedef struct packed
	{
		logic [7:0]    page;
		logic          cp_rsvd;
		logic [2:0]    cp_load;
		logic [3:0]    cp_div;
		logic [6:0]    cp_ratio;
		logic          hp_comp;
		chcar_couple_e hp_couple;
		logic          hp_gc;
		chcar_power_e  hp_power;
		chcar_dcoc_e   hp_dcoc;
		logic          af_en;
		logic          swap_req;
		logic          host_bank_b;
		logic          swap_pulse;
		logic [7:0]    rdata;
	} chcar_state_s;

endpackage

// [chcar_props.sv]
`timescale 1ns/1ps
module chcar_props
(
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// frame timing and outputs watched
	input wire logic       frame_boundary,
	input wire logic [7:0] page_sel,
	input wire logic [2:0] cp_load_sel,
	input wire logic [6:0] cp_div_ratio,
	input wire logic       cp_rsvd_bit,
	input wire logic       hp_comp_adjust,
	input wire logic [1:0] hp_gain_couple,
	input wire logic       hp_ground_centred,
	input wire logic [1:0] hp_power_rating,
	input wire logic [1:0] hp_dcoc_mode,
	input wire logic       adaptive_en,
	input wire logic       filter_bank_b,
	input wire logic       bank_swapped
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire cp_wr = reg_wr && page_sel == 8'h01 && reg_addr == 7'h7c;
	wire hp_wr = reg_wr && page_sel == 8'h01 && reg_addr == 7'h7d;

	property p_page;
		reg_wr && reg_addr == 7'h00 |=> page_sel == $past(reg_wdata);
	endproperty
	a_page: assert property (p_page) else $error("page select not stored");
	property p_cp;
		cp_wr |=> {cp_rsvd_bit, cp_load_sel} == $past(reg_wdata[7:4])
			&& cp_div_ratio == ($past(reg_wdata[3:0]) == 4'h0 ? 7'h40 : {1'b0, $past(reg_wdata[3:0]), 2'b00});
	endproperty
	a_cp: assert property (p_cp) else $error("charge pump fields wrong");
	property p_hp;
		hp_wr |=> {hp_comp_adjust, hp_gain_couple, hp_ground_centred, hp_power_rating, hp_dcoc_mode}
			== $past(reg_wdata);
	endproperty
	a_hp: assert property (p_hp) else $error("headphone fields wrong");
	property p_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	property p_rsvd;
		reg_rd && page_sel == 8'h01 && reg_addr[6:1] == 6'h3f |=> reg_rdata == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved offset not zero");
	property p_flag;
		reg_rd && page_sel == 8'h08 && reg_addr == 7'h01 |=> reg_rdata[2:1] == $past({adaptive_en, filter_bank_b});
	endproperty
	a_flag: assert property (p_flag) else $error("adaptive status read wrong");
	property p_swap;
		bank_swapped |-> $past(frame_boundary) && $past(adaptive_en) && filter_bank_b != $past(filter_bank_b);
	endproperty
	a_swap: assert property (p_swap) else $error("swap without cause");
	property p_hold;
		!bank_swapped |-> $stable(filter_bank_b);
	endproperty
	a_hold: assert property (p_hold) else $error("bank flag moved");
endmodule

bind codec_hp_cp_adaptive_regs chcar_props u_props(.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .frame_boundary, .page_sel, .cp_load_sel, .cp_div_ratio, .cp_rsvd_bit, .hp_comp_adjust,
	.hp_gain_couple, .hp_ground_centred, .hp_power_rating, .hp_dcoc_mode, .adaptive_en, .filter_bank_b,
	.bank_swapped);

// [codec_hp_cp_adaptive_regs.sv]
// Function
// R1 - three-bit charge pump load field, eighths of peak load current
// R2 - four-bit charge pump divider, n times four, zero gives sixty-four
// R3 - two-bit headphone gain coupling: independent, right master, left master, reserved
// R4 - host sets equal left and right gains before choosing a master mode
// R5 - one-bit ground-centred headphone mode enable
// R6 - host enables the charge pump whenever ground-centred mode is on
// R7 - two-bit headphone power rating: 100, 75, 50, 25 percent
// R8 - two-bit DC offset correction mode, code one reserved
// R9 - offsets 0x7e and 0x7f read zero; host writes only zero there
// R10 - register 0 of every page selects the page for later accesses
// R11 - one-bit adaptive filtering enable
// R12 - read-only flag shows which coefficient bank the filter uses
// R13 - writing one requests a bank swap at next frame; clears on swap
// R14 - all defined fields reset to zero
// R15 - host touches coefficients only with ADC off when adaptive disabled
// R16 - flag inverts per completed swap; no swap while adaptive disabled
// R17 - compensation bit and charge pump bit 7 are plain storage
`include "codec_hp_cp_adaptive_regs.svh"
`timescale 1ns/1ps
module codec_hp_cp_adaptive_regs
	import chcar_pkg::*;
#(
	parameter int ADDR_W  = 7,
	parameter int DATA_W  = 8,
	parameter int RATIO_W = 7
)
(
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset,
	// register port
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [DATA_W-1:0]  reg_rdata,
	// filter timing
	input  wire logic               frame_boundary,
	// page in use
	output logic      [7:0]         page_sel,
	// charge pump
	output logic      [2:0]         cp_load_sel,
	output logic      [RATIO_W-1:0] cp_div_ratio,
	output logic                    cp_clk_en,
	output logic                    cp_rsvd_bit,
	// headphone drivers
	output logic                    hp_comp_adjust,
	output logic      [1:0]         hp_gain_couple,
	output logic                    hp_ground_centred,
	output logic      [1:0]         hp_power_rating,
	output logic      [1:0]         hp_dcoc_mode,
	// adaptive filter
	output logic                    adaptive_en,
	output logic                    filter_bank_b,
	output logic                    host_bank_b,
	output logic                    bank_swapped
);

	chcar_state_s state;
	chcar_state_s next_state;

	logic swap_now;
	logic bank_flag;
	logic cp_tick;

	// divider code to clock ratio
	function automatic logic [RATIO_W-1:0] cp_ratio_of(input logic [3:0] code);
		logic [RATIO_W-1:0] ratio;
		ratio = `CHCAR_CP_DIV_ZERO_RATIO;
		if (code != 4'h0)
			ratio = RATIO_W'({3'h0, code} * `CHCAR_CP_DIV_STEP);
		return ratio;
	endfunction

	// address match within a page
	function automatic logic hit(
		input logic [7:0]        page,
		input logic [ADDR_W-1:0] addr,
		input logic [7:0]        want_page,
		input logic [ADDR_W-1:0] want_addr
	);
		return (page == want_page) && (addr == want_addr);
	endfunction

	// charge pump register image
	function automatic logic [7:0] cp_image(input chcar_state_s s);
		return {s.cp_rsvd, s.cp_load, s.cp_div};
	endfunction

	// headphone register image
	function automatic logic [7:0] hp_image(input chcar_state_s s);
		return {s.hp_comp, s.hp_couple, s.hp_gc, s.hp_power, s.hp_dcoc};
	endfunction

	chcar_bank_swap u_swap
	(
		.clk_sys        (clk_sys),
		.reset          (reset),
		.frame_boundary (frame_boundary),
		.adaptive_en    (state.af_en),
		.swap_req       (state.swap_req),
		.swap_now       (swap_now),
		.bank_flag      (bank_flag)
	);

	chcar_cp_divider #(
		.RATIO_W (RATIO_W)
	) u_div
	(
		.clk_sys (clk_sys),
		.reset   (reset),
		.ratio   (state.cp_ratio),
		.tick    (cp_tick)
	);

	always_comb
	begin
		next_state            = state;
		next_state.rdata      = '0;
		next_state.swap_pulse = swap_now;

		// request retires with the swap
		if (swap_now)
			next_state.swap_req = 1'b0; // R13

		// writes
		if (reg_wr)
		begin
			if (reg_addr == `CHCAR_PAGE_SELECTOR_OFS)
			begin
				next_state.page = reg_wdata[7:0]; // R10
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_CHARGE_PUMP_CTRL_OFS))
			begin
				next_state.cp_rsvd = reg_wdata[`CHCAR_CP_RSVD_BIT]; // R17
				next_state.cp_load = reg_wdata[`CHCAR_CP_LOAD_MSB:`CHCAR_CP_LOAD_LSB]; // R1
				next_state.cp_div  = reg_wdata[`CHCAR_CP_DIV_MSB:`CHCAR_CP_DIV_LSB]; // R2
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_HP_DRIVER_CFG_OFS))
			begin
				next_state.hp_comp   = reg_wdata[`CHCAR_HP_COMP_BIT]; // R17
				next_state.hp_couple = chcar_couple_e'(reg_wdata[`CHCAR_HP_COUPLE_MSB:`CHCAR_HP_COUPLE_LSB]); // R3
				next_state.hp_gc     = reg_wdata[`CHCAR_HP_GC_BIT]; // R5
				next_state.hp_power  = chcar_power_e'(reg_wdata[`CHCAR_HP_POWER_MSB:`CHCAR_HP_POWER_LSB]); // R7
				next_state.hp_dcoc   = chcar_dcoc_e'(reg_wdata[`CHCAR_HP_DCOC_MSB:`CHCAR_HP_DCOC_LSB]); // R8
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ADAPTIVE, `CHCAR_ADAPTIVE_CTRL_OFS))
			begin
				next_state.af_en = reg_wdata[`CHCAR_AF_ENABLE_BIT]; // R11
				// a new request beats a same-cycle retire
				if (reg_wdata[`CHCAR_AF_SWITCH_BIT])
					next_state.swap_req = 1'b1; // R13
			end
			// reserved and unmapped offsets drop the write
		end

		// derived charge pump ratio
		next_state.cp_ratio = cp_ratio_of(next_state.cp_div); // R2

		// host sees the bank the filter is not using from one cycle after a swap; zero while adaptive is off
		if (next_state.af_en)
			next_state.host_bank_b = ~bank_flag; // R12
		else
			next_state.host_bank_b = 1'b0;

		// reads
		if (reg_rd)
		begin
			if (reg_addr == `CHCAR_PAGE_SELECTOR_OFS)
			begin
				next_state.rdata = state.page; // R10
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_CHARGE_PUMP_CTRL_OFS))
			begin
				next_state.rdata = cp_image(state);
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_HP_DRIVER_CFG_OFS))
			begin
				next_state.rdata = hp_image(state);
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_RESERVED_A_OFS))
			begin
				next_state.rdata = `CHCAR_RESERVED_RST; // R9
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ANALOG, `CHCAR_RESERVED_B_OFS))
			begin
				next_state.rdata = `CHCAR_RESERVED_RST; // R9
			end
			else if (hit(state.page, reg_addr, `CHCAR_PAGE_ADAPTIVE, `CHCAR_ADAPTIVE_CTRL_OFS))
			begin
				next_state.rdata = {5'h00, state.af_en, bank_flag, state.swap_req}; // R12
			end
			else
			begin
				next_state.rdata = '0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state             <= '0; // R14
			state.page        <= `CHCAR_PAGE_SELECTOR_RST; // R10
			state.cp_ratio    <= `CHCAR_CP_DIV_ZERO_RATIO;
		end
		else
		begin
			state <= next_state;
		end
	end

	// outputs
	assign reg_rdata         = state.rdata;
	assign page_sel          = state.page;
	assign cp_load_sel       = state.cp_load;
	assign cp_div_ratio      = state.cp_ratio;
	assign cp_clk_en         = cp_tick;
	assign cp_rsvd_bit       = state.cp_rsvd;
	assign hp_comp_adjust    = state.hp_comp;
	assign hp_gain_couple    = state.hp_couple;
	assign hp_ground_centred = state.hp_gc;
	assign hp_power_rating   = state.hp_power;
	assign hp_dcoc_mode      = state.hp_dcoc;
	assign adaptive_en       = state.af_en;
	assign filter_bank_b     = bank_flag;
	assign host_bank_b       = state.host_bank_b;
	assign bank_swapped      = state.swap_pulse;

endmodule

// [codec_hp_cp_adaptive_regs.svh]
`ifndef CHCAR_REGS_SVH
`define CHCAR_REGS_SVH

// register offsets within a page
`define CHCAR_PAGE_SELECTOR_OFS       7'h00
`define CHCAR_ADAPTIVE_CTRL_OFS       7'h01
`define CHCAR_CHARGE_PUMP_CTRL_OFS    7'h7c
`define CHCAR_HP_DRIVER_CFG_OFS       7'h7d
`define CHCAR_RESERVED_A_OFS          7'h7e
`define CHCAR_RESERVED_B_OFS          7'h7f

// pages holding the block's registers
`define CHCAR_PAGE_ANALOG             8'h01
`define CHCAR_PAGE_ADAPTIVE           8'h08

// reset values
`define CHCAR_PAGE_SELECTOR_RST       8'h00
`define CHCAR_ADAPTIVE_CTRL_RST       8'h00
`define CHCAR_CHARGE_PUMP_CTRL_RST    8'h00
`define CHCAR_HP_DRIVER_CFG_RST       8'h00
`define CHCAR_RESERVED_RST            8'h00

// charge pump control fields
`define CHCAR_CP_RSVD_BIT             7
`define CHCAR_CP_LOAD_MSB             6
`define CHCAR_CP_LOAD_LSB             4
`define CHCAR_CP_DIV_MSB              3
`define CHCAR_CP_DIV_LSB              0

// headphone driver fields
`define CHCAR_HP_COMP_BIT             7
`define CHCAR_HP_COUPLE_MSB           6
`define CHCAR_HP_COUPLE_LSB           5
`define CHCAR_HP_GC_BIT               4
`define CHCAR_HP_POWER_MSB            3
`define CHCAR_HP_POWER_LSB            2
`define CHCAR_HP_DCOC_MSB             1
`define CHCAR_HP_DCOC_LSB             0

// adaptive filter control fields
`define CHCAR_AF_ENABLE_BIT           2
`define CHCAR_AF_FLAG_BIT             1
`define CHCAR_AF_SWITCH_BIT           0

// charge pump divider arithmetic
`define CHCAR_CP_DIV_STEP             7'h04
`define CHCAR_CP_DIV_ZERO_RATIO       7'h40

`endif

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic       clk_sys = 1'b0;
	logic       reset = 1'b1;
	logic       frame_boundary = 1'b0;
	logic [6:0] reg_addr, cp_div_ratio;
	logic [7:0] reg_wdata, reg_rdata, page_sel, v;
	logic [2:0] cp_load_sel;
	logic [1:0] hp_gain_couple, hp_power_rating, hp_dcoc_mode;
	logic       reg_wr, reg_rd, cp_clk_en, cp_rsvd_bit, hp_comp_adjust, hp_ground_centred;
	logic       adaptive_en, filter_bank_b, host_bank_b, bank_swapped, sw;
	int         failures = 0;
	int         compares = 0;
	int         n;

	always #2.5 clk_sys = ~clk_sys;

	codec_hp_cp_adaptive_regs dut(.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.frame_boundary, .page_sel, .cp_load_sel, .cp_div_ratio, .cp_clk_en, .cp_rsvd_bit, .hp_comp_adjust,
		.hp_gain_couple, .hp_ground_centred, .hp_power_rating, .hp_dcoc_mode, .adaptive_en, .filter_bank_b,
		.host_bank_b, .bank_swapped);
	chcar_host_model host(.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	task check(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask
	task conclude;
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task rchk(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, v);
		check(v, e);
	endtask
	task frame;
		@(posedge clk_sys);
		frame_boundary <= 1'b1;
		@(posedge clk_sys);
		frame_boundary <= 1'b0;
		#1 sw = bank_swapped;
		@(posedge clk_sys);
		#1;
	endtask

	initial
	begin
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		check(cp_div_ratio, 8'h40);
		rchk(7'h00, 8'h00);
		host.wr(7'h00, 8'h01);
		check(page_sel, 8'h01);
		rchk(7'h7c, 8'h00);
		rchk(7'h7d, 8'h00);
		for (n = 0; n < 16; n++)
		begin
			host.wr(7'h7c, {n[3], n[2:0], n[3:0]});
			check(cp_load_sel, n[2:0]);
			check(cp_div_ratio, n == 0 ? 8'h40 : 8'(n * 4));
			check(cp_rsvd_bit, n[3]);
			rchk(7'h7c, {n[3], n[2:0], n[3:0]});
		end
		for (n = 0; n < 4; n++)
		begin
			host.wr(7'h7d, {n[0], n[1:0], n[0], n[1:0], n[1:0]});
			check({hp_comp_adjust, hp_gain_couple, hp_ground_centred}, {n[0], n[1:0], n[0]});
			check({hp_power_rating, hp_dcoc_mode}, {n[1:0], n[1:0]});
		end
		rchk(7'h7d, 8'hff);
		host.wr(7'h7e, 8'h00);
		rchk(7'h7e, 8'h00);
		rchk(7'h7f, 8'h00);
		rchk(7'h7b, 8'h00);
		// pump tick spacing at ratio 60
		n = 0;
		while (cp_clk_en !== 1'b1 && n < 200)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1 n++;
		end while (cp_clk_en !== 1'b1 && n < 200);
		check(8'(n), 8'd60);
		if (n >= 200)
		begin
			failures++;
			conclude;
		end
		host.wr(7'h00, 8'h08);
		rchk(7'h7c, 8'h00);
		host.wr(7'h01, 8'h01);
		frame;
		check(filter_bank_b, 1'b0);
		check(sw, 1'b0);
		rchk(7'h01, 8'h01);
		host.wr(7'h01, 8'hfd);
		frame;
		check({filter_bank_b, host_bank_b}, 2'b10);
		check(sw, 1'b1);
		rchk(7'h01, 8'h06);
		host.wr(7'h01, 8'h05);
		frame;
		check({filter_bank_b, host_bank_b}, 2'b01);
		check(sw, 1'b1);
		rchk(7'h01, 8'h04);
		host.wr(7'h01, 8'h00);
		check(adaptive_en, 1'b0);
		host.wr(7'h00, 8'h01);
		rchk(7'h7c, 8'hff);
		conclude;
	end
endmodule
